// ---- core/serial_control_register_bank.sv ----
// serial write port and twelve-bit control register bank
module serial_control_register_bank
  import serial_ctrl_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_serial_data_in,
  input  wire logic       i_serial_clock_in,
  input  wire logic       i_load_strobe,
  input  wire logic       i_summed_input_select,
  input  wire logic       i_header_field,
  output logic [2:0]      o_summed_input_gain,
  output logic            o_summed_gain_valid,
  output logic [1:0]      o_first_rf_gain,
  output logic [1:0]      o_second_rf_gain,
  output logic [3:0]      o_third_rf_gain,
  output logic [5:0]      o_rf_left_offset,
  output logic [5:0]      o_rf_right_offset,
  output logic [5:0]      o_rf_sum_offset,
  output logic [6:0]      o_rf_bandwidth_limit,
  output logic [1:0]      o_common_servo_offset,
  output logic [3:0]      o_input_e_radial_offset,
  output logic            o_commit_pulse
);
  // synchronised pins
  logic sda_s;   // serial data after sync
  logic scl_s;   // serial clock after sync
  logic ld_s;    // load strobe after sync
  logic ld_s_n;  // inverted strobe after sync, low while deselected
  logic sel_s;   // summed select after sync
  logic hdr_s;   // header pin after sync

  serial_pin_sync u_sync_sda
  (
    .i_clk   (i_clk),
    .i_arst_n(i_arst_n),
    .i_async (i_serial_data_in),
    .o_sync  (sda_s)
  );
  serial_pin_sync u_sync_scl
  (
    .i_clk   (i_clk),
    .i_arst_n(i_arst_n),
    .i_async (i_serial_clock_in),
    .o_sync  (scl_s)
  );
  serial_pin_sync u_sync_ld
  (
    .i_clk   (i_clk),
    .i_arst_n(i_arst_n),
    .i_async (~i_load_strobe),
    .o_sync  (ld_s_n)
  );
  // the chain resets low, so it carries the inverted strobe: reset then
  // reads as deselected, the pin's idle level, and no phantom rise
  // commits a stale word just after reset
  assign ld_s = ~ld_s_n;
  serial_pin_sync u_sync_sel
  (
    .i_clk   (i_clk),
    .i_arst_n(i_arst_n),
    .i_async (i_summed_input_select),
    .o_sync  (sel_s)
  );
  serial_pin_sync u_sync_hdr
  (
    .i_clk   (i_clk),
    .i_arst_n(i_arst_n),
    .i_async (i_header_field),
    .o_sync  (hdr_s)
  );

  // edge history and shift state
  logic              scl_d_ff;     // previous sampled clock
  logic              ld_d_ff;      // previous sampled strobe
  logic [WORD_W-1:0] shift_ff;     // input shift register
  logic [WORD_W-1:0] nxt_shift;
  logic              commit_ff;    // one-cycle commit marker
  logic              nxt_commit;
  logic              scl_rise;
  logic              ld_rise;

  // stored bank, sixteen slots of twelve bits
  logic [DATA_W-1:0] bank_ff  [NUM_REGS];
  logic [DATA_W-1:0] nxt_bank [NUM_REGS];

  assign scl_rise = scl_s & ~scl_d_ff;
  assign ld_rise  = ld_s & ~ld_d_ff;

  // shift and commit next-state; strobe level gates the shifter
  always_comb
  begin
    nxt_shift  = shift_ff;
    nxt_commit = ld_rise;  // [R6]
    if (!ld_s && scl_rise)  // [R3]
    begin
      // msb first: new bit enters at the bottom  [R18]
      nxt_shift = {shift_ff[WORD_W-2:0], sda_s};  // [R5]
    end
  end

  // bank next-state, one slot per generate entry; no standby gating
  // so writes land regardless of the power bit  [R1]
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_bank
    always_comb
    begin
      nxt_bank[g] = bank_ff[g];
      // address in top nibble, data below  [R7] [R8]
      if (ld_rise && shift_ff[ADDR_MSB:ADDR_LSB] == ADDR_W'(g))  // [R6]
      begin
        nxt_bank[g] = shift_ff[DATA_MSB:0];
      end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        bank_ff[g] <= REG_RESET;
      else
        bank_ff[g] <= nxt_bank[g];
    end
  end

  // register shift state
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      scl_d_ff  <= 1'b0;
      ld_d_ff   <= 1'b1;  // idle strobe level, no edge after reset
      shift_ff  <= '0;
      commit_ff <= 1'b0;
    end
    else
    begin
      scl_d_ff  <= scl_s;
      ld_d_ff   <= ld_s;
      shift_ff  <= nxt_shift;
      commit_ff <= nxt_commit;
    end
  end

  // field decode into output flops
  logic [2:0] sum_gain;
  logic [DATA_W-1:0] r0;
  logic [DATA_W-1:0] r3;
  logic [DATA_W-1:0] r4;
  logic [DATA_W-1:0] r5;
  logic [DATA_W-1:0] r11;
  logic [DATA_W-1:0] r14;
  logic [2:0] nxt_sum_gain;
  logic       nxt_sum_ok;
  logic [1:0] nxt_g1;
  logic [1:0] nxt_g2;
  logic [3:0] nxt_g3;
  logic [5:0] nxt_left;
  logic [5:0] nxt_right;
  logic [5:0] nxt_sum_ofs;
  logic [6:0] nxt_bw;
  logic [1:0] nxt_com;
  logic [3:0] nxt_e;

  // outputs follow the bank the cycle after the slot is written
  always_comb
  begin
    r0  = bank_ff[ADDR_POWER_SUM];
    r3  = bank_ff[ADDR_RF_GAIN];
    r4  = bank_ff[ADDR_RF_DATA_OFS];
    r5  = bank_ff[ADDR_RF_HDR_OFS];
    r11 = bank_ff[ADDR_SERVO_OFS];
    r14 = bank_ff[ADDR_RF_BW];
    sum_gain     = r0[SUM_GAIN_MSB:SUM_GAIN_LSB];  // [R13]
    nxt_sum_gain = sum_gain;
    // codes above four name no gain; flagged rather than clamped  [R14]
    nxt_sum_ok   = (sum_gain <= SUM_GAIN_MAX);
    nxt_g1 = r3[G1_MSB:G1_LSB];  // [R9]
    nxt_g2 = r3[G2_MSB:G2_LSB];  // [R9]
    // header pin picks the third-stage field  [R10]
    nxt_g3 = hdr_s ? r3[G3_HDR_MSB:G3_HDR_LSB]
                   : r3[G3_DATA_MSB:G3_DATA_LSB];
    // data and header offsets apply only without summed input  [R12]
    if (sel_s)
    begin
      nxt_left    = 6'h00;
      nxt_right   = 6'h00;
      nxt_sum_ofs = r4[OFS_RIGHT_MSB:OFS_RIGHT_LSB];  // [R11]
    end
    else if (hdr_s)
    begin
      nxt_left    = r5[OFS_LEFT_MSB:OFS_LEFT_LSB];  // [R12]
      nxt_right   = r5[OFS_RIGHT_MSB:OFS_RIGHT_LSB];
      nxt_sum_ofs = 6'h00;
    end
    else
    begin
      nxt_left    = r4[OFS_LEFT_MSB:OFS_LEFT_LSB];  // [R11]
      nxt_right   = r4[OFS_RIGHT_MSB:OFS_RIGHT_LSB];
      nxt_sum_ofs = 6'h00;
    end
    nxt_bw  = r14[BW_MSB:BW_LSB];        // [R15]
    nxt_com = r11[COM_OFS_MSB:COM_OFS_LSB];  // [R16]
    nxt_e   = r11[E_OFS_MSB:E_OFS_LSB];      // [R17]
  end

  logic [2:0] sum_gain_ff;
  logic       sum_ok_ff;
  logic [1:0] g1_ff;
  logic [1:0] g2_ff;
  logic [3:0] g3_ff;
  logic [5:0] left_ff;
  logic [5:0] right_ff;
  logic [5:0] sum_ofs_ff;
  logic [6:0] bw_ff;
  logic [1:0] com_ff;
  logic [3:0] e_ff;

  // register decoded fields
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sum_gain_ff <= 3'h0;
      sum_ok_ff   <= 1'b1;
      g1_ff       <= 2'h0;
      g2_ff       <= 2'h0;
      g3_ff       <= 4'h0;
      left_ff     <= 6'h00;
      right_ff    <= 6'h00;
      sum_ofs_ff  <= 6'h00;
      bw_ff       <= 7'h00;
      com_ff      <= 2'h0;
      e_ff        <= 4'h0;
    end
    else
    begin
      sum_gain_ff <= nxt_sum_gain;
      sum_ok_ff   <= nxt_sum_ok;
      g1_ff       <= nxt_g1;
      g2_ff       <= nxt_g2;
      g3_ff       <= nxt_g3;
      left_ff     <= nxt_left;
      right_ff    <= nxt_right;
      sum_ofs_ff  <= nxt_sum_ofs;
      bw_ff       <= nxt_bw;
      com_ff      <= nxt_com;
      e_ff        <= nxt_e;
    end
  end

  assign o_summed_input_gain     = sum_gain_ff;
  assign o_summed_gain_valid     = sum_ok_ff;
  assign o_first_rf_gain         = g1_ff;
  assign o_second_rf_gain        = g2_ff;
  assign o_third_rf_gain         = g3_ff;
  assign o_rf_left_offset        = left_ff;
  assign o_rf_right_offset       = right_ff;
  assign o_rf_sum_offset         = sum_ofs_ff;
  assign o_rf_bandwidth_limit    = bw_ff;
  assign o_common_servo_offset   = com_ff;
  assign o_input_e_radial_offset = e_ff;
  assign o_commit_pulse          = commit_ff;

  // checks
  a_strobe_freezes_shift: assert property (  // [R3]
    @(posedge i_clk) disable iff (!i_arst_n)
    $past(ld_s) |-> shift_ff == $past(shift_ff))
    else $error("shift register moved while strobe high");

  a_shift_msb_first: assert property (  // [R18]
    @(posedge i_clk) disable iff (!i_arst_n)
    (!ld_s && scl_rise) |=> shift_ff[0] == $past(sda_s)
      && shift_ff[WORD_W-1:1] == $past(shift_ff[WORD_W-2:0]))
    else $error("serial bit not shifted in at bottom");

  a_commit_writes_slot: assert property (  // [R6]
    @(posedge i_clk) disable iff (!i_arst_n)
    ld_rise |=> bank_ff[$past(shift_ff[ADDR_MSB:ADDR_LSB])]
      == $past(shift_ff[DATA_MSB:0]))
    else $error("commit did not store addressed data");

  a_bank_holds_idle: assert property (  // [R5]
    @(posedge i_clk) disable iff (!i_arst_n)
    !ld_rise |=> bank_ff[ADDR_RF_GAIN] == $past(bank_ff[ADDR_RF_GAIN]))
    else $error("bank changed without commit");

  a_commit_pulse_once: assert property (  // [R6]
    @(posedge i_clk) disable iff (!i_arst_n)
    ld_rise |=> o_commit_pulse ##1 !o_commit_pulse)
    else $error("commit pulse not single cycle");

  a_gain_tracks_bank: assert property (  // [R9]
    @(posedge i_clk) disable iff (!i_arst_n)
    ld_rise && shift_ff[ADDR_MSB:ADDR_LSB] == ADDR_RF_GAIN
      |-> ##2 o_first_rf_gain == $past(shift_ff[G1_MSB:G1_LSB], 2))
    else $error("first gain not updated two cycles after commit");

  a_sum_offset_route: assert property (  // [R11]
    @(posedge i_clk) disable iff (!i_arst_n)
    sel_s |=> o_rf_left_offset == 6'h00
      && o_rf_sum_offset == $past(r4[OFS_RIGHT_MSB:OFS_RIGHT_LSB]))
    else $error("summed offset routing wrong");

  a_third_gain_pick: assert property (  // [R10]
    @(posedge i_clk) disable iff (!i_arst_n)
    hdr_s |=> o_third_rf_gain == $past(r3[G3_HDR_MSB:G3_HDR_LSB]))
    else $error("header third gain not selected");

  a_bw_field: assert property (  // [R15]
    @(posedge i_clk) disable iff (!i_arst_n)
    ##1 o_rf_bandwidth_limit == $past(r14[BW_MSB:BW_LSB]))
    else $error("bandwidth output does not follow slot 14");

  a_sum_gain_valid: assert property (  // [R14]
    @(posedge i_clk) disable iff (!i_arst_n)
    ##1 o_summed_gain_valid == ($past(sum_gain) <= SUM_GAIN_MAX))
    else $error("summed gain validity wrong");
endmodule : serial_control_register_bank

// ---- core/serial_ctrl_pkg.sv ----
// Contract
// [R1] writes accepted always, even in standby
// [R2] controller keeps data stable while clock high
// [R3] load strobe high: ignore data and clock
// [R4] controller frames only its own words with strobe
// [R5] shift bits in, stored registers untouched
// [R6] strobe rising edge commits word to address
// [R7] word is 4 address plus 12 data bits
// [R8] address in bits 15..12, data 11..0
// [R9] reg 3: first and second gain selects
// [R10] reg 3: third gain, data and header fields
// [R11] reg 4: data offsets, right doubles as sum
// [R12] reg 5: header offsets when sum not selected
// [R13] reg 0: summed gain select bits 7..5
// [R14] summed gain codes 0..4, -6 to 18 dB
// [R15] reg 14: seven-bit rf bandwidth limit
// [R16] reg 11: common servo offset bits 11..10
// [R17] reg 11: input e offset bits 7..4
// [R18] msb first, sampled on rising clock edge
package serial_ctrl_pkg;
  localparam int WORD_W     = 16;  // whole serial word
  localparam int ADDR_W     = 4;   // address field width
  localparam int DATA_W     = 12;  // data field width
  localparam int ADDR_MSB   = 15;  // address field position
  localparam int ADDR_LSB   = 12;
  localparam int DATA_MSB   = 11;
  localparam int NUM_REGS   = 16;  // sixteen addressable slots
  localparam logic [DATA_W-1:0] REG_RESET = 12'h000;  // all settings clear
  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_POWER_SUM   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RF_GAIN     = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RF_DATA_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_RF_HDR_OFS  = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_SERVO_OFS   = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_RF_BW       = 4'hE;
  // field positions
  localparam int SUM_GAIN_MSB   = 7;
  localparam int SUM_GAIN_LSB   = 5;
  localparam int G1_MSB         = 11;
  localparam int G1_LSB         = 10;
  localparam int G2_MSB         = 9;
  localparam int G2_LSB         = 8;
  localparam int G3_DATA_MSB    = 7;
  localparam int G3_DATA_LSB    = 4;
  localparam int G3_HDR_MSB     = 3;
  localparam int G3_HDR_LSB     = 0;
  localparam int OFS_LEFT_MSB   = 11;
  localparam int OFS_LEFT_LSB   = 6;
  localparam int OFS_RIGHT_MSB  = 5;
  localparam int OFS_RIGHT_LSB  = 0;
  localparam int BW_MSB         = 6;
  localparam int BW_LSB         = 0;
  localparam int COM_OFS_MSB    = 11;
  localparam int COM_OFS_LSB    = 10;
  localparam int E_OFS_MSB      = 7;
  localparam int E_OFS_LSB      = 4;
  localparam logic [2:0] SUM_GAIN_MAX = 3'h4;  // highest legal gain code
endpackage : serial_ctrl_pkg

// ---- core/serial_pin_sync.sv ----
// two-flop synchroniser for one asynchronous pin
module serial_pin_sync
  import serial_ctrl_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_ff;  // first stage, read only by second stage
  logic sync_ff;  // second stage

  // plain two-stage chain
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule : serial_pin_sync

// ---- verification/serial_control_register_bank_bench.sv ----
// self-checking bench for the serial control register bank
module serial_control_register_bank_bench
  import serial_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk;          // 125 MHz system clock
  logic              arst_n;       // asynchronous reset, active low
  logic              sel;          // summed input select pin
  logic              hdr;          // header pin
  wire logic         sda;          // serial data from the controller
  wire logic         scl;          // serial clock from the controller
  wire logic         sld;          // load strobe from the controller
  wire logic         commit;       // commit pulse from the bank
  wire logic [42:0]  act;          // all field outputs side by side
  logic [DATA_W-1:0] regs [16];    // model of the stored slots
  logic [15:0]       sh;           // model of the input shift register
  logic [42:0]       expq [$];     // expected fields per commit
  int                num_errors;   // mismatches seen
  int                n_checks;     // comparisons made
  integer            seed = 32'h4EC5;

  always #4 clk = ~clk;

  serial_control_register_bank serial_control_register_bank_i (
    .i_clk                   (clk),
    .i_arst_n                (arst_n),
    .i_serial_data_in        (sda),
    .i_serial_clock_in       (scl),
    .i_load_strobe           (sld),
    .i_summed_input_select   (sel),
    .i_header_field          (hdr),
    .o_summed_input_gain     (act[42:40]),
    .o_summed_gain_valid     (act[39]),
    .o_first_rf_gain         (act[38:37]),
    .o_second_rf_gain        (act[36:35]),
    .o_third_rf_gain         (act[34:31]),
    .o_rf_left_offset        (act[30:25]),
    .o_rf_right_offset       (act[24:19]),
    .o_rf_sum_offset         (act[18:13]),
    .o_rf_bandwidth_limit    (act[12:6]),
    .o_common_servo_offset   (act[5:4]),
    .o_input_e_radial_offset (act[3:0]),
    .o_commit_pulse          (commit)
  );

  serial_word_source serial_word_source_i (
    .i_clk    (clk),
    .o_data   (sda),
    .o_sclk   (scl),
    .o_strobe (sld)
  );

  // fields the pins should show for the model slots and routing pins
  function automatic logic [42:0] exp_out();
    logic [11:0] r3;
    logic [11:0] ro;
    r3 = regs[3];
    ro = hdr ? regs[5] : regs[4];
    return {regs[0][7:5], regs[0][7:5] <= 3'h4,
      r3[11:10], r3[9:8], hdr ? r3[3:0] : r3[7:4],
      sel ? 6'h00 : ro[11:6], sel ? 6'h00 : ro[5:0],
      sel ? regs[4][5:0] : 6'h00, regs[14][6:0],
      regs[11][11:10], regs[11][7:4]};
  endfunction : exp_out

  // compare every field output at once
  task automatic chk(input logic [42:0] e, input string m);
    n_checks++;
    if (act !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: %s exp %h got %h", $time, m, e, act);
    end
  endtask : chk

  // one framed word; routing pins are reshuffled first
  task automatic wr(input logic [31:0] w, input int n);
    {sel, hdr} = 2'($random(seed));
    serial_word_source_i.shift(w, n);
    for (int i = n - 1; i >= 0; i--)
      sh = {sh[14:0], w[i]};
    chk(exp_out(), "fields moved mid-word");
    regs[sh[15:12]] = sh[11:0];
    expq.push_back(exp_out());
    serial_word_source_i.load();
  endtask : wr

  // fields settle one cycle after the commit pulse
  always @(negedge clk)
    if (commit === 1'b1)
    begin
      @(negedge clk);
      if (expq.size() == 0)
      begin
        num_errors++;
        $display("wrong value at %0t: unexpected commit", $time);
      end
      else
        chk(expq.pop_front(), "after commit");
    end

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // about 60 frames of 140 cycles; allow more than twice that
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    conclude();
  end

  // main sequence
  initial
  begin
    clk    = 1'b0;
    arst_n = 1'b0;
    sel    = 1'b0;
    hdr    = 1'b0;
    sh     = 16'h0000;
    foreach (regs[i])
      regs[i] = 12'h000;
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(exp_out(), "reset values");
    $display("test reset done");
    // every gain code, power bit random so standby is hit too
    for (int k = 0; k < 8; k++)
      wr({8'($random(seed)) & 8'h0F, k[2:0], 5'($random(seed))}, 16);
    $display("test sum gain done");
    // all sixteen addresses, mapped and unused, three rounds
    repeat (3)
      for (int a = 0; a < 16; a++)
        wr({a[3:0], 12'($random(seed))}, 16);
    $display("test all slots done");
    // deselected clocking shifts nothing; short word keeps old bits
    wr({8'h00, 4'h3, 4'($random(seed))}, 16);
    serial_word_source_i.foreign($random(seed), 8);
    wr($random(seed), 8);
    $display("test deselect done");
    // overlong word: only the last sixteen bits count
    wr($random(seed), 24);
    $display("test long word done");
    repeat (12) @(posedge clk);
    #1;
    if (expq.size() != 0)
    begin
      num_errors++;
      $display("wrong value at %0t: commit missing", $time);
    end
    conclude();
  end
endmodule : serial_control_register_bank_bench

// ---- verification/serial_word_source.sv ----
// behavioural system controller driving the three serial pins
module serial_word_source
(
  input  wire logic i_clk,
  output logic      o_data,
  output logic      o_sclk,
  output logic      o_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 4;  // half of the 64 ns serial period

  // idle: deselected, serial clock parked low between frames
  initial
  begin
    o_data   = 1'b1;
    o_sclk   = 1'b0;
    o_strobe = 1'b1;
  end

  // wait n system edges, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  // one bit of a 64 ns period; data moves a cycle after the clock falls
  task automatic bit_out(input logic b);
    tick(1);
    o_data = b;
    tick(HALF - 1);
    o_sclk = 1'b1;
    tick(HALF);
    o_sclk = 1'b0;
  endtask : bit_out

  // select the device and shift n bits, msb first
  task automatic shift(input logic [31:0] w, input int n);
    o_strobe = 1'b0;
    tick(HALF);
    for (int i = n - 1; i >= 0; i--)
      bit_out(w[i]);
    tick(HALF);
  endtask : shift

  // strobe rise commits; the data line no longer holds its last value
  task automatic load();
    o_strobe = 1'b1;
    o_data   = ~o_data;
    tick(HALF);
  endtask : load

  // traffic for another device on shared lines, strobe kept high
  task automatic foreign(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
      bit_out(w[i]);
    tick(1);
    o_data = ~o_data;
  endtask : foreign
endmodule : serial_word_source
